// ---- rtl/mco_pkg.sv ----
// Constants for the clock, reset-delay, watchdog and timer option block.
// Assumes one 100 MHz system clock and classic Wishbone register access.
`default_nettype none
package mco_pkg;
  localparam int CLK_MHZ = 100;
  localparam int CLK_KHZ = CLK_MHZ * 1000;
  // Frequency measurement window
  localparam int WIN_NS      = 10_000;
  localparam int WIN_CYC     = WIN_NS * CLK_MHZ / 1000;
  localparam int KHZ_PER_CNT = 1_000_000 / WIN_NS;
  localparam int OSC0_KHZ = 16_000;
  localparam int OSC1_KHZ = 8_000;
  localparam int OSC2_KHZ = 4_000;
  localparam int OSC3_KHZ = 2_000;
  localparam int CPU_FREQUENCY_MIN_KHZ = 250;
  localparam int CPU_FREQUENCY_MAX_KHZ = 8_000;
  localparam int PLL_MIN_KHZ  = 2_000;
  localparam int PLL_MAX_KHZ  = 4_000;
  // High band edges in window counts; each lower band halves them
  localparam int BAND_HI_CNT = 16_000 / KHZ_PER_CNT;
  localparam int BAND_LO_CNT = 8_000 / KHZ_PER_CNT;
  localparam int DLY_LONG  = 4096;
  localparam int DLY_SHORT = 256;
  // Register byte addresses
  localparam logic [7:0] A_CTRL    = 8'h00;
  localparam logic [7:0] A_STATUS  = 8'h04;
  localparam logic [7:0] A_IRQ_EN  = 8'h08;
  localparam logic [7:0] A_IRQ_CLR = 8'h0C;
  localparam logic [7:0] A_STATE   = 8'h10;
  localparam logic [7:0] A_TMR0    = 8'h20;
  localparam logic [7:0] A_TMR1    = 8'h30;
  localparam logic [7:0] T_CTRL    = 8'h00;
  localparam logic [7:0] T_CMP     = 8'h04;
  localparam logic [7:0] T_CAP     = 8'h08;
  localparam logic [7:0] T_CNT     = 8'h0C;
  // Control register fields
  localparam int F_OSC_SEL  = 0;
  localparam int F_DOUBLER  = 3;
  localparam int F_SLOW     = 4;
  localparam int F_CSS_EN   = 7;
  localparam int F_BAND     = 8;
  localparam int F_RST_DLY  = 10;
  localparam int F_WATCHDOG_ON_HALT = 11;
  localparam int F_WDG_HW   = 12;
  localparam int F_WATCHDOG_ENABLE_SOURCE   = 13;
  localparam int F_VD_OPT   = 14;
  localparam int F_FREEZE   = 15;
  localparam int CTRL_W     = 16;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [2:0]  OSC_EXT  = 3'h4;
  // Timer control fields
  localparam int F_T_PRESC = 0;
  localparam int F_T_EXT   = 4;
  // Status and interrupt bits
  localparam int E_BACKUP  = 0;
  localparam int E_WDG_RST = 1;
  localparam int E_OVF0    = 2;
  localparam int E_CAP0    = 4;
  localparam int EVT_W     = 6;
  typedef enum logic [1:0] {
    MCO_BAND_HIGH   = 2'b00,
    MCO_BAND_MEDIUM = 2'b01,
    MCO_BAND_MIDLOW = 2'b10,
    MCO_BAND_LOW    = 2'b11
  } mco_band_e;
endpackage
`default_nettype wire

// ---- rtl/mco_clock_options.sv ----
// Clock source, cpu clock enable, supervisor, reset delay, watchdog option
// and two timers. Clocks are modelled as one-cycle ticks synchronous to clk_i.
//
// Design decisions made here: the Wishbone register port and the register addresses.
`default_nettype none
module mco_clock_options
  import mco_pkg::*;
#(
  parameter int BACKUP_KHZ = 8_000
)(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [3:0]  osc_tick_i,
  input  wire logic        external_clock_input_i,
  input  wire logic        backup_tick_i,
  input  wire logic        halt_i,
  input  wire logic        halt_exec_i,
  input  wire logic        stopped_i,
  input  wire logic [1:0]  tmr_ext_i,
  input  wire logic [1:0]  tmr_cap_i,
  output logic             cpu_tick_o,
  output logic             cpu_reset_o,
  output logic             chip_reset_o,
  output logic             on_backup_o,
  output logic             wdg_enable_o,
  output logic             evd_enable_o,
  output logic             lvd_enable_o,
  output logic             irq_o,
  output logic      [1:0]  tmr_pwm_o
);

  function automatic logic [31:0] byte_mask(input logic [3:0] sel);
    byte_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  logic [CTRL_W-1:0] ctrl;
  logic [EVT_W-1:0]  status;
  logic [EVT_W-1:0]  irq_en;
  logic [16:0]       cpu_khz;
  logic [16:0]       acc;
  logic [9:0]        win_cnt;
  logic [10:0]       edge_cnt;
  logic [10:0]       meas_q;
  logic              fail_pend;
  logic [12:0]       dly_cnt;
  logic              halt_q;
  logic [15:0]       t_ctrl [2];
  logic [15:0]       t_cmp  [2];
  logic [15:0]       t_cap  [2];
  logic [15:0]       t_cnt  [2];
  logic [15:0]       t_pcnt [2];
  logic [1:0]        t_ovf;
  logic [1:0]        t_capt;
  logic [1:0]        t_pwm;

  // Bus decode
  wire        req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire        wr       = ce_i && req && wb_we_i;
  wire [31:0] wmask    = byte_mask(wb_sel_i);
  wire [31:0] wdat_m   = wb_dat_i & wmask;
  wire        tmr_hit  = (wb_adr_i & 8'hE0) == A_TMR0;
  wire        tmr_idx  = wb_adr_i[4];
  wire [7:0]  tmr_off  = wb_adr_i & 8'h0F;
  wire        wr_ctrl  = wr && (wb_adr_i == A_CTRL);
  wire        wr_en    = wr && (wb_adr_i == A_IRQ_EN);
  wire        wr_clr   = wr && (wb_adr_i == A_IRQ_CLR);

  // Control fields
  wire [2:0]  osc_sel   = ctrl[F_OSC_SEL +: 3];
  wire        doubler   = ctrl[F_DOUBLER];
  wire [2:0]  slow_exp  = ctrl[F_SLOW +: 3];
  wire        css_en    = ctrl[F_CSS_EN];
  wire [1:0]  band      = ctrl[F_BAND +: 2];
  wire        dly_short = ctrl[F_RST_DLY];
  wire        watchdog_on_halt  = ctrl[F_WATCHDOG_ON_HALT];
  wire        wdg_hw    = ctrl[F_WDG_HW];
  wire        watchdog_enable_source    = ctrl[F_WATCHDOG_ENABLE_SOURCE];
  wire        vd_opt    = ctrl[F_VD_OPT];
  wire        freeze    = ctrl[F_FREEZE];

  // Oscillator selection and frequency
  wire src_tick = (osc_sel == OSC_EXT) ? external_clock_input_i
                : (osc_sel < OSC_EXT) ? osc_tick_i[osc_sel[1:0]] : 1'b0;
  wire [16:0] ext_khz = 17'(meas_q) * 17'(KHZ_PER_CNT);
  wire [16:0] main_khz =
      (osc_sel == 3'h0) ? 17'(OSC0_KHZ) :
      (osc_sel == 3'h1) ? 17'(OSC1_KHZ) :
      (osc_sel == 3'h2) ? 17'(OSC2_KHZ) :
      (osc_sel == 3'h3) ? 17'(OSC3_KHZ) : ext_khz;
  wire [16:0] fosc_khz = on_backup_o ? 17'(BACKUP_KHZ) : main_khz;
  wire [17:0] pre_slow = doubler ? {fosc_khz, 1'b0}
                                 : {2'b00, fosc_khz[16:1]};
  wire [17:0] raw_khz  = pre_slow >> slow_exp;
  wire [16:0] next_cpu_khz =
      (raw_khz < 18'(CPU_FREQUENCY_MIN_KHZ)) ? 17'(CPU_FREQUENCY_MIN_KHZ) :
      (raw_khz > 18'(CPU_FREQUENCY_MAX_KHZ)) ? 17'(CPU_FREQUENCY_MAX_KHZ) : raw_khz[16:0];
  wire pll_out_of_range = doubler &&
      ((fosc_khz < 17'(PLL_MIN_KHZ)) || (fosc_khz > 17'(PLL_MAX_KHZ)));

  // Cpu clock enable by fractional accumulation
  wire [16:0] acc_sum  = acc + cpu_khz;
  wire        cpu_hit  = acc_sum >= 17'(CLK_KHZ);
  wire [16:0] next_acc = cpu_hit ? acc_sum - 17'(CLK_KHZ) : acc_sum;

  // Supervisor measurement over a fixed window
  wire        win_end    = win_cnt == 10'(WIN_CYC - 1);
  wire [10:0] edge_total = edge_cnt + 11'(src_tick);
  wire [10:0] band_lo    = 11'(BAND_LO_CNT) >> band;
  wire [10:0] band_hi    = 11'(BAND_HI_CNT) >> band;
  wire        out_band   = (edge_total < band_lo) || (edge_total > band_hi);
  wire        next_pend  = css_en && !on_backup_o &&
                           (fail_pend || (win_end && out_band));
  // Switch to backup happens only on a cpu tick; clearing css_en leaves backup in any cycle
  wire        next_backup = cpu_hit ? (css_en && (on_backup_o || fail_pend))
                                    : (css_en && on_backup_o);

  // Reset delay and watchdog
  wire        wdg_on      = wdg_hw || watchdog_enable_source;
  wire        halt_rst    = halt_exec_i && wdg_on && watchdog_on_halt;
  wire        halt_exit   = halt_q && !halt_i;
  wire [12:0] dly_load    = dly_short ? 13'(DLY_SHORT) : 13'(DLY_LONG);
  wire        dly_start   = halt_exit || halt_rst;
  wire [12:0] next_dly    = dly_start ? dly_load
                          : (cpu_hit && dly_cnt != 13'h0000) ? dly_cnt - 13'h0001
                          : dly_cnt;

  // Events and sticky status: a set in the clearing cycle wins
  wire [EVT_W-1:0] evt;
  assign evt[E_BACKUP]        = next_backup && !on_backup_o;
  assign evt[E_WDG_RST]       = halt_rst;
  assign evt[E_OVF0 +: 2]     = t_ovf;
  assign evt[E_CAP0 +: 2]     = t_capt;
  wire [EVT_W-1:0] clr_mask   = wr_clr ? wdat_m[EVT_W-1:0] : '0;
  wire [EVT_W-1:0] next_status = (status & ~clr_mask) | evt;

  // Timers
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : gen_tmr
      wire        sel_t   = tmr_hit && (tmr_idx == 1'(g));
      wire        run     = !(freeze && stopped_i);
      wire [15:0] pmask   = (16'h0001 << t_ctrl[g][F_T_PRESC +: 4]) - 16'h0001;
      wire        p_hit   = t_pcnt[g] == pmask;
      wire        use_ext = t_ctrl[g][F_T_EXT];
      // External timer clock bypasses the stop gating
      wire        inc     = use_ext ? tmr_ext_i[g]
                                    : (cpu_hit && run && p_hit);
      assign t_ovf[g]  = ce_i && inc && (t_cnt[g] == 16'hFFFF);
      assign t_capt[g] = ce_i && tmr_cap_i[g];

      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          t_ctrl[g] <= 16'h0000;
          t_cmp[g]  <= 16'h0000;
          t_cap[g]  <= 16'h0000;
          t_cnt[g]  <= 16'h0000;
          t_pcnt[g] <= 16'h0000;
          t_pwm[g]  <= 1'b0;
        end
        else if (ce_i)
        begin
          if (wr && sel_t && tmr_off == T_CTRL)
            t_ctrl[g] <= (t_ctrl[g] & ~wmask[15:0]) | wdat_m[15:0];
          if (wr && sel_t && tmr_off == T_CMP)
            t_cmp[g] <= (t_cmp[g] & ~wmask[15:0]) | wdat_m[15:0];
          if (cpu_hit && run)
            t_pcnt[g] <= p_hit ? 16'h0000 : t_pcnt[g] + 16'h0001;
          if (inc)
            t_cnt[g] <= t_cnt[g] + 16'h0001;
          if (tmr_cap_i[g])
            t_cap[g] <= t_cnt[g];
          t_pwm[g] <= t_cnt[g] < t_cmp[g];
        end
      end
    end
  endgenerate

  // Read data selection
  logic [31:0] next_rdat;
  always_comb
  begin
    next_rdat = 32'h0000_0000;
    if (wb_adr_i == A_CTRL)
      next_rdat = 32'(ctrl);
    else if (wb_adr_i == A_STATUS)
      next_rdat = 32'(status);
    else if (wb_adr_i == A_IRQ_EN)
      next_rdat = 32'(irq_en);
    else if (wb_adr_i == A_STATE)
      next_rdat = {11'h000, pll_out_of_range, cpu_reset_o, on_backup_o,
                   1'b0, cpu_khz};
    else if (tmr_hit && tmr_off == T_CTRL)
      next_rdat = 32'(t_ctrl[tmr_idx]);
    else if (tmr_hit && tmr_off == T_CMP)
      next_rdat = 32'(t_cmp[tmr_idx]);
    else if (tmr_hit && tmr_off == T_CAP)
      next_rdat = 32'(t_cap[tmr_idx]);
    else if (tmr_hit && tmr_off == T_CNT)
      next_rdat = 32'(t_cnt[tmr_idx]);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl     <= CTRL_RST;
      status   <= '0;
      irq_en   <= '0;
      irq_o    <= 1'b0;
    end
    else if (ce_i)
    begin
      wb_ack_o <= req;
      wb_dat_o <= (req && !wb_we_i) ? next_rdat : 32'h0000_0000;
      if (wr_ctrl)
        ctrl <= (ctrl & ~wmask[CTRL_W-1:0]) | wdat_m[CTRL_W-1:0];
      if (wr_en)
        irq_en <= wdat_m[EVT_W-1:0];
      status <= next_status;
      irq_o  <= |(next_status & irq_en);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cpu_khz   <= 17'(CPU_FREQUENCY_MIN_KHZ);
      acc       <= '0;
      cpu_tick_o <= 1'b0;
      win_cnt   <= '0;
      edge_cnt  <= '0;
      meas_q    <= '0;
      fail_pend <= 1'b0;
      on_backup_o <= 1'b0;
    end
    else if (ce_i)
    begin
      cpu_khz    <= next_cpu_khz;
      acc        <= next_acc;
      cpu_tick_o <= cpu_hit;
      win_cnt    <= win_end ? '0 : win_cnt + 10'h001;
      edge_cnt   <= win_end ? '0 : edge_total;
      if (win_end)
        meas_q <= edge_total;
      fail_pend   <= next_pend;
      on_backup_o <= next_backup;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dly_cnt      <= 13'(DLY_LONG);
      cpu_reset_o  <= 1'b1;
      halt_q       <= 1'b0;
      chip_reset_o <= 1'b0;
      wdg_enable_o <= 1'b0;
      evd_enable_o <= 1'b0;
      lvd_enable_o <= 1'b0;
    end
    else if (ce_i)
    begin
      halt_q       <= halt_i;
      dly_cnt      <= next_dly;
      cpu_reset_o  <= next_dly != 13'h0000;
      chip_reset_o <= halt_rst;
      wdg_enable_o <= wdg_on;
      evd_enable_o <= vd_opt;
      lvd_enable_o <= vd_opt && !halt_i;
    end
  end

  assign tmr_pwm_o = t_pwm;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_next_cycle: assert property (ce_i && req |=> wb_ack_o)
    else $error("request not answered in next cycle");
  a_cpu_band_kept: assert property (cpu_khz >= 17'(CPU_FREQUENCY_MIN_KHZ) &&
                                    cpu_khz <= 17'(CPU_FREQUENCY_MAX_KHZ))
    else $error("cpu frequency left its band");
  a_halt_wdg_reset: assert property (ce_i && halt_exec_i && wdg_on && watchdog_on_halt
                                     |=> chip_reset_o)
    else $error("halt with watchdog did not reset chip");
  a_halt_no_reset: assert property (ce_i && !watchdog_on_halt |=> !chip_reset_o)
    else $error("chip reset with no-reset option");
  a_lvd_halt_off: assert property (ce_i && halt_i |=> !lvd_enable_o)
    else $error("low-voltage detector on in halt");
  a_wdg_hw_source: assert property (ce_i && wdg_hw |=> wdg_enable_o)
    else $error("hardware watchdog not enabled");
  a_timer_frozen: assert property (ce_i && freeze && stopped_i &&
                                   !t_ctrl[0][F_T_EXT] |=> $stable(t_cnt[0]))
    else $error("timer counted while frozen at breakpoint");
  a_backup_needs_css: assert property ($rose(on_backup_o) |-> $past(css_en))
    else $error("backup selected without supervisor");
  a_backup_on_tick: assert property ($rose(on_backup_o) |-> cpu_tick_o)
    else $error("backup switch not aligned to cpu tick");
  a_delay_after_halt: assert property (ce_i && halt_exit |=> cpu_reset_o [*2])
    else $error("halt exit did not hold cpu reset");

  c_backup_switch: cover property ($rose(on_backup_o));
  c_chip_reset: cover property (chip_reset_o);
  c_timer_capture: cover property (t_capt[0]);
  c_irq_raised: cover property ($rose(irq_o));

endmodule
`default_nettype wire

// ---- dv/mco_osc_model.sv ----
// Far-side model: probe oscillators, external clock pin and backup oscillator.
// Assumes a 100 MHz clk_i; every source is a phase accumulator giving one-cycle ticks.
`default_nettype none
module mco_osc_model
#(
  parameter int BACKUP_KHZ = 8_000
)(
  input  wire logic        clk_i,
  input  wire logic [31:0] ext_khz_i,
  output logic      [3:0]  osc_tick_o,
  output logic             ext_tick_o,
  output logic             backup_tick_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] tick = '0;
  int         acc [6] = '{default: 0};
  // Probe sources halve from 16 MHz down to 2 MHz
  function automatic int rate(input int i);
    return (i < 4) ? (16_000 >> i) : ((i == 4) ? int'(ext_khz_i) : BACKUP_KHZ);
  endfunction
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < 6; i++)
    begin
      acc[i]  <= (acc[i] + rate(i)) % 100_000;
      tick[i] <= (acc[i] + rate(i)) >= 100_000;
    end
  end
  assign osc_tick_o    = tick[3:0];
  assign ext_tick_o    = tick[4];
  assign backup_tick_o = tick[5];
endmodule
`default_nettype wire

// ---- dv/mco_clock_options_bench.sv ----
// Self-checking bench for the clock, reset-delay and watchdog option block.
// Assumes the oscillator model supplies the source ticks; the bench drives bus, run control and timer inputs.
`default_nettype none
module mco_clock_options_bench import mco_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] ctrl; logic [31:0] st;} mco_row_s;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000, rdat, r, a, b, ext_khz = 32'h0000_2EE0;
  logic        ack, ext_t, bk_t, cpu_t, cpu_rst, chip_rst, on_bk, wdg, external_voltage_detect, low_voltage_detector, irq;
  logic        halt = 1'b0, halt_x = 1'b0, stop = 1'b0;
  logic [1:0]  text = 2'b00, tcap = 2'b00, pwm;
  logic [3:0]  osc;
  int          n_fail = 0, total_checks = 0, cyc_cnt = 0, n, k;
  mco_row_s    rows [8] = '{'{32'h0000_0000, 32'h0000_1F40}, '{32'h0000_0001, 32'h0000_0FA0},
    '{32'h0000_000A, 32'h0000_1F40}, '{32'h0000_000B, 32'h0000_0FA0},
    '{32'h0000_0013, 32'h0000_01F4}, '{32'h0000_0060, 32'h0000_00FA},
    '{32'h0000_0008, 32'h0010_1F40}, '{32'h0000_0029, 32'h0010_0FA0}};
  logic [31:0] bands [4] = '{32'h0000_0482, 32'h0000_0580, 32'h0000_0680, 32'h0000_0780};

  always #5 clk_i = ~clk_i;

  mco_osc_model osc_m (.clk_i(clk_i), .ext_khz_i(ext_khz), .osc_tick_o(osc),
    .ext_tick_o(ext_t), .backup_tick_o(bk_t));
  mco_clock_options uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .osc_tick_i(osc), .external_clock_input_i(ext_t),
    .backup_tick_i(bk_t), .halt_i(halt), .halt_exec_i(halt_x), .stopped_i(stop),
    .tmr_ext_i(text), .tmr_cap_i(tcap), .cpu_tick_o(cpu_t), .cpu_reset_o(cpu_rst),
    .chip_reset_o(chip_rst), .on_backup_o(on_bk), .wdg_enable_o(wdg), .evd_enable_o(external_voltage_detect),
    .lvd_enable_o(low_voltage_detector), .irq_o(irq), .tmr_pwm_o(pwm));

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, m, got, exp);
    end
  endtask

  // Classic single cycle; request held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d,
                     output logic [31:0] q);
    int i;
    i = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    dat <= d;
    do
    begin
      @(posedge clk_i);
      i++;
    end while (ack !== 1'b1 && i < 50);
    q = rdat;
    chk(32'(ack), 1, "bus ack");
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, ad, d, x);
  endtask

  task automatic rd(input logic [7:0] ad, output logic [31:0] q);
    bus(1'b0, ad, 32'h0000_0000, q);
  endtask

  task automatic wait_bk(input logic v);
    k = 0;
    while (on_bk !== v && k < 3000)
    begin
      @(posedge clk_i);
      k++;
    end
    chk(32'(on_bk), 32'(v), "backup state");
  endtask

  task automatic halt_pulse();
    halt_x <= 1'b1;
    @(posedge clk_i);
    halt_x <= 1'b0;
    @(posedge clk_i);
  endtask

  always @(posedge clk_i)
  begin
    cyc_cnt++;
    if (cyc_cnt == 95_000)
    begin
      n_fail++;
      results();
    end
  end

  initial
  begin
    repeat (5) @(posedge clk_i);
    chk({cpu_rst, chip_rst, on_bk, wdg, external_voltage_detect, low_voltage_detector, irq, ack}, 32'h0000_0080, "reset outs");
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (rows[i])
    begin
      wr(A_CTRL, rows[i].ctrl);
      rd(A_STATE, r);
      chk(r & 32'h0015_FFFF, rows[i].st, "cpu rate");
    end
    $display("rate table done");
    for (int j = 0; j < 2; j++)
    begin
      wr(A_CTRL, j ? 32'h0000_4000 : 32'h0000_4400);
      halt <= 1'b1;
      repeat (2) @(posedge clk_i);
      chk(32'(low_voltage_detector), 0, "lvd in halt");
      chk(32'(external_voltage_detect), 1, "evd on");
      halt <= 1'b0;
      repeat (2) @(posedge clk_i);
      n = 0;
      k = 0;
      while (cpu_rst === 1'b1 && k < 60_000)
      begin
        @(posedge clk_i);
        k++;
        n += (cpu_t === 1'b1);
      end
      chk(32'(n >= (j ? 4095 : 255) && n <= (j ? 4097 : 257)), 1, "delay ticks");
      chk(32'(low_voltage_detector), 1, "lvd after halt");
    end
    $display("reset delay done");
    wr(A_IRQ_EN, 32'h0000_0002);
    wr(A_CTRL, 32'h0000_2C00);
    chk(32'(wdg), 1, "wdg soft");
    halt_pulse();
    chk(32'(chip_rst), 1, "halt reset");
    repeat (3) @(posedge clk_i);
    chk(32'(irq), 1, "irq raised");
    wr(A_IRQ_EN, 32'h0000_0000);
    chk(32'(irq), 0, "irq masked");
    wr(A_IRQ_EN, 32'h0000_0002);
    wr(A_IRQ_CLR, 32'h0000_0002);
    chk(32'(irq), 0, "irq cleared");
    rd(A_STATUS, r);
    chk(r & 32'h0000_0002, 0, "status cleared");
    rd(8'h7C, r);
    chk(r, 0, "unmapped read");
    wr(A_CTRL, 32'h0000_2400);
    halt_pulse();
    chk(32'(chip_rst), 0, "no halt reset");
    wr(A_CTRL, 32'h0000_1400);
    chk(32'(wdg), 1, "wdg hard");
    wr(A_CTRL, 32'h0000_0400);
    chk({30'h0, wdg, external_voltage_detect}, 0, "wdg and evd off");
    $display("watchdog done");
    ext_khz <= 32'h0000_2EE0;
    wr(A_CTRL, 32'h0000_0484);
    repeat (3000) @(posedge clk_i);
    rd(A_STATE, r);
    chk(r & 32'h0005_FFFF, 32'h0000_1770, "external in band");
    foreach (bands[i])
    begin
      wr(A_CTRL, bands[i] & 32'h0000_FF7F);
      wait_bk(1'b0);
      wr(A_CTRL, bands[i]);
      wait_bk(1'b1);
    end
    rd(A_STATUS, r);
    chk(r & 32'h0000_0001, 1, "backup status");
    $display("supervisor done");
    wr(A_CTRL, 32'h0000_8400);
    wr(A_TMR0 + T_CTRL, 32'h0000_0000);
    stop <= 1'b1;
    rd(A_TMR0 + T_CNT, a);
    repeat (100) @(posedge clk_i);
    rd(A_TMR0 + T_CNT, b);
    chk(b, a, "frozen count");
    wr(A_CTRL, 32'h0000_0400);
    rd(A_TMR0 + T_CNT, a);
    repeat (100) @(posedge clk_i);
    rd(A_TMR0 + T_CNT, b);
    chk(32'(b != a), 1, "free count");
    wr(A_CTRL, 32'h0000_8400);
    wr(A_TMR0 + T_CTRL, 32'h0000_0010);
    rd(A_TMR0 + T_CNT, a);
    repeat (3)
    begin
      text[0] <= 1'b1;
      @(posedge clk_i);
      text[0] <= 1'b0;
      @(posedge clk_i);
    end
    rd(A_TMR0 + T_CNT, b);
    chk(b - a, 3, "external count");
    wr(A_TMR0 + T_CMP, 32'h0000_FFFF);
    chk(32'(pwm[0]), 1, "pwm high below compare");
    wr(A_TMR0 + T_CMP, 32'h0000_0000);
    chk(32'(pwm[0]), 0, "pwm low at compare");
    tcap[0] <= 1'b1;
    @(posedge clk_i);
    tcap[0] <= 1'b0;
    @(posedge clk_i);
    rd(A_TMR0 + T_CAP, r);
    chk(r, b, "capture value");
    rd(A_STATUS, r);
    chk(r & 32'h0000_0010, 32'h0000_0010, "capture status");
    $display("timers done");
    // Reset in mid-run must bring the reset, backup, enable, irq and ack outputs back to their idle level
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk({cpu_rst, chip_rst, on_bk, wdg, external_voltage_detect, low_voltage_detector, irq, ack}, 32'h0000_0080, "mid reset outs");
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(A_CTRL, r);
    chk(r, 0, "ctrl after mid reset");
    $display("mid reset done");
    results();
  end
endmodule
`default_nettype wire
